// file: rtl/supervisor_pkg.sv
package supervisor_pkg;

  // Local clock rate.
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;

  // Reset hold-off time in milliseconds.
  localparam int unsigned HOLDOFF_TIME_MS  = 200;
  localparam int unsigned HOLDOFF_MIN_MS   = 140;
  localparam int unsigned HOLDOFF_MAX_MS   = 280;

  // Watchdog kick timeout in milliseconds.
  localparam int unsigned KICK_TIMEOUT_MS  = 1600;
  localparam int unsigned KICK_MIN_MS      = 1000;
  localparam int unsigned KICK_MAX_MS      = 2250;

  // Cycle counts derived from the times above.
  localparam int unsigned HOLDOFF_CYC      = HOLDOFF_TIME_MS * CYC_PER_MS;
  localparam int unsigned HOLDOFF_MIN_CYC  = HOLDOFF_MIN_MS * CYC_PER_MS;
  localparam int unsigned HOLDOFF_MAX_CYC  = HOLDOFF_MAX_MS * CYC_PER_MS;
  localparam int unsigned KICK_CYC         = KICK_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned KICK_MIN_CYC     = KICK_MIN_MS * CYC_PER_MS;
  localparam int unsigned KICK_MAX_CYC     = KICK_MAX_MS * CYC_PER_MS;

  // Counter width and synchroniser reset levels.
  localparam int unsigned CNT_W            = 28;
  localparam logic        MR_IDLE          = 1'h1;
  localparam logic        KICK_IDLE        = 1'h0;

endpackage : supervisor_pkg

// file: rtl/sync_two_stage.sv
`timescale 1ns/100ps
`default_nettype none

module sync_two_stage #(
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : sync_two_stage

`default_nettype wire

// file: rtl/supervisor_reset_watchdog.sv
// Contract
// - System reset held asserted while the supply is reported invalid.
// - After supply recovers, reset stays asserted for the 200 ms hold-off.
// - Hold-off lies between 140 and 280 ms, typically 200 ms.
// - No kick transition within the timeout flags expiry and resets.
// - Watchdog timeout lies between 1.0 and 2.25 s, typically 1.6 s.
// - A watchdog reset also holds for the 200 ms hold-off.
// - Any kick edge, or a pulse held across a clock edge, restarts the watchdog from zero.
// - Expired output stays high with timely kicks or with low supply.
// - Gated chip-select follows input when supply valid, else forced high.
// - Manual reset low asserts reset; one hold-off after it returns high.
// - Active-high reset is always the complement of active-low reset.
`timescale 1ns/100ps
`default_nettype none

module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES    = HOLDOFF_CYC,
  parameter int unsigned KICK_CYCLES       = KICK_CYC,
  parameter logic        WDOG_DRIVES_RESET = 1'h1
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic supply_ok_i,
  input  wire logic manual_rst_n_i,
  input  wire logic wdog_kick_i,
  input  wire logic mem_ce_n_i,
  output logic      sys_rst_n_o,
  output logic      sys_rst_o,
  output logic      wdog_expired_n_o,
  output logic      mem_ce_n_o
);

  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLDOFF_CYCLES);
  localparam logic [CNT_W-1:0] KICK_LAST = CNT_W'(KICK_CYCLES - 1);

  logic             mr_n_s;
  logic             kick_s;
  logic             kick_prev_q;
  logic             kick_edge;
  logic [CNT_W-1:0] hold_q;
  logic [CNT_W-1:0] hold_d;
  logic [CNT_W-1:0] wd_q;
  logic             wd_run;
  logic             wdog_fire;
  logic             rst_cond;

  sync_two_stage #(.RST_VAL(MR_IDLE)) u_sync_mr (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (manual_rst_n_i),
    .sync_o    (mr_n_s)
  );

  sync_two_stage #(.RST_VAL(KICK_IDLE)) u_sync_kick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (wdog_kick_i),
    .sync_o    (kick_s)
  );

  // Edge detection on the synchronised kick level.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      kick_prev_q <= KICK_IDLE;
    end else begin
      kick_prev_q <= kick_s;
    end
  end

  assign kick_edge = kick_s ^ kick_prev_q;
  assign wd_run    = supply_ok_i && sys_rst_n_o;
  assign wdog_fire = wd_run && !kick_edge && (wd_q == KICK_LAST);
  assign rst_cond  = !supply_ok_i || !mr_n_s
                     || (wdog_fire && WDOG_DRIVES_RESET);

  // Hold-off counter reloads while any reset cause is present.
  always_comb begin
    if (rst_cond) begin
      hold_d = HOLD_LOAD;
    end else if (hold_q != '0) begin
      hold_d = hold_q - CNT_W'(1);
    end else begin
      hold_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hold_q      <= HOLD_LOAD;
      sys_rst_n_o <= 1'h0;
      sys_rst_o   <= 1'h1;
    end else begin
      hold_q      <= hold_d;
      sys_rst_n_o <= !rst_cond && (hold_d == '0);
      sys_rst_o   <= rst_cond || (hold_d != '0);
    end
  end

  // Watchdog counter runs only while supply is valid and reset released.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wd_q <= '0;
    end else if (!wd_run || kick_edge || wdog_fire) begin
      wd_q <= '0;
    end else begin
      wd_q <= wd_q + CNT_W'(1);
    end
  end

  // Expired flag stays low until a kick edge or a supply drop.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wdog_expired_n_o <= 1'h1;
    end else if (!supply_ok_i || kick_edge) begin
      wdog_expired_n_o <= 1'h1;
    end else if (wdog_fire) begin
      wdog_expired_n_o <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mem_ce_n_o <= 1'h1;
    end else begin
      mem_ce_n_o <= supply_ok_i ? mem_ce_n_i : 1'h1;
    end
  end

  // Helper: cycles spent in reset since the last reset cause went away.
  logic [CNT_W-1:0] seen_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || rst_cond) begin
      seen_q <= '0;
    end else if (!sys_rst_n_o) begin
      seen_q <= seen_q + CNT_W'(1);
    end
  end

  property p_supply_rst;
    @(posedge sys_clk_i) disable iff (rst_i)
      !supply_ok_i |=> !sys_rst_n_o;
  endproperty
  a_supply_rst: assert property (p_supply_rst)
    else $error("Reset not asserted during low supply.");

  property p_holdoff;
    @(posedge sys_clk_i) disable iff (rst_i)
      $rose(sys_rst_n_o) |-> (seen_q == HOLD_LOAD);
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("Reset released after wrong hold-off length.");

  property p_hold_range;
    @(posedge sys_clk_i) disable iff (rst_i)
      $rose(sys_rst_n_o) |->
        (64'(seen_q) * HOLDOFF_TIME_MS
           >= 64'(HOLDOFF_CYCLES) * HOLDOFF_MIN_MS)
        && (64'(seen_q) * HOLDOFF_TIME_MS
           <= 64'(HOLDOFF_CYCLES) * HOLDOFF_MAX_MS);
  endproperty
  a_hold_range: assert property (p_hold_range)
    else $error("Hold-off count outside allowed range.");

  property p_wd_fire;
    @(posedge sys_clk_i) disable iff (rst_i)
      $fell(wdog_expired_n_o) |-> ($past(wd_q) == KICK_LAST)
                                  && !sys_rst_n_o;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("Watchdog expiry at wrong count or without reset.");

  property p_kick_range;
    @(posedge sys_clk_i) disable iff (rst_i)
      $fell(wdog_expired_n_o) |->
        (64'($past(wd_q)) + 64'h1) * KICK_TIMEOUT_MS
          >= 64'(KICK_CYCLES) * KICK_MIN_MS
        && (64'($past(wd_q)) + 64'h1) * KICK_TIMEOUT_MS
          <= 64'(KICK_CYCLES) * KICK_MAX_MS;
  endproperty
  a_kick_range: assert property (p_kick_range)
    else $error("Watchdog timeout outside allowed range.");

  property p_kick_restart;
    @(posedge sys_clk_i) disable iff (rst_i)
      kick_edge |=> (wd_q == '0) && wdog_expired_n_o;
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("Kick did not restart the watchdog.");

  property p_wd_low_supply;
    @(posedge sys_clk_i) disable iff (rst_i)
      !supply_ok_i |=> wdog_expired_n_o && (wd_q == '0);
  endproperty
  a_wd_low_supply: assert property (p_wd_low_supply)
    else $error("Watchdog active during low supply.");

  property p_ce_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      1'h1 |=> mem_ce_n_o == ($past(supply_ok_i) ? $past(mem_ce_n_i) : 1'h1);
  endproperty
  a_ce_gate: assert property (p_ce_gate)
    else $error("Chip-select gating wrong.");

  property p_manual;
    @(posedge sys_clk_i) disable iff (rst_i)
      !manual_rst_n_i ##1 !manual_rst_n_i |-> ##2 !sys_rst_n_o;
  endproperty
  a_manual: assert property (p_manual)
    else $error("Manual reset did not assert reset.");

  property p_complement;
    @(posedge sys_clk_i) disable iff (rst_i)
      sys_rst_o != sys_rst_n_o;
  endproperty
  a_complement: assert property (p_complement)
    else $error("Reset outputs not complementary.");

  property p_powerup;
    @(posedge sys_clk_i)
      rst_i |=> !sys_rst_n_o && (wd_q == '0) && (hold_q == HOLD_LOAD);
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("Power-up state wrong.");

endmodule : supervisor_reset_watchdog

`default_nettype wire

// file: testbench/cpu_kicker.sv
`timescale 1ns/100ps
`default_nettype none

module cpu_kicker #(
  parameter int unsigned PERIOD = 10
) (
  input  wire logic sys_clk_i,
  input  wire logic kick_en_i,
  output logic      wdog_kick_o
);
  int unsigned cnt     = 0;
  logic        level_q = 1'h0;

  assign wdog_kick_o = level_q;

  // Each kick level is held PERIOD cycles before it toggles.
  always @(posedge sys_clk_i) begin
    cnt = (cnt + 1) % PERIOD;
    if (kick_en_i && cnt == 0) level_q <= #1 ~level_q;
  end
endmodule : cpu_kicker

`default_nettype wire

// file: testbench/test_supervisor_reset_watchdog.sv
`timescale 1ns/100ps
`default_nettype none

module test_supervisor_reset_watchdog;
  localparam int H = 20;
  localparam int K = 50;
  logic sys_clk_i, rst_i, supply_ok_i, manual_rst_n_i, mem_ce_n_i;
  logic kick_en, wdog_kick_i, sys_rst_n_o, sys_rst_o;
  logic wdog_expired_n_o, mem_ce_n_o;
  int   err_count, checks, cyc, n;

  supervisor_reset_watchdog #(.HOLDOFF_CYCLES(H), .KICK_CYCLES(K))
    u_supervisor_reset_watchdog (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i),
    .manual_rst_n_i(manual_rst_n_i), .wdog_kick_i(wdog_kick_i),
    .mem_ce_n_i(mem_ce_n_i), .sys_rst_n_o(sys_rst_n_o),
    .sys_rst_o(sys_rst_o), .wdog_expired_n_o(wdog_expired_n_o),
    .mem_ce_n_o(mem_ce_n_o));

  cpu_kicker #(.PERIOD(10)) u_cpu_kicker (
    .sys_clk_i(sys_clk_i), .kick_en_i(kick_en), .wdog_kick_o(wdog_kick_i));

  task finish_test;
    $display("Checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task check1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check1

  task checkn(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkn

  task step(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask : step

  // Counts cycles until the system reset is released.
  task rel_count(output int cnt);
    cnt = 0;
    while (sys_rst_n_o !== 1'h1 && cnt < 1000) begin
      step(1);
      cnt++;
    end
  endtask : rel_count

  task t_powerup;
    check1(sys_rst_n_o, 1'h0);
    check1(wdog_expired_n_o, 1'h1);
    rst_i = 1'h0;
    rel_count(n);
    checkn(int'(n >= H && n <= H + 2), 1);
  endtask : t_powerup

  task t_supply;
    step(5);
    supply_ok_i = 1'h0;
    mem_ce_n_i = 1'h0;
    step(1);
    check1(sys_rst_n_o, 1'h0);
    step(30);
    check1(sys_rst_n_o, 1'h0);
    check1(wdog_expired_n_o, 1'h1);
    check1(mem_ce_n_o, 1'h1);
    supply_ok_i = 1'h1;
    rel_count(n);
    checkn(n, H);
    for (int i = 0; i < 3; i++) begin
      mem_ce_n_i = i[0];
      step(1);
      check1(mem_ce_n_o, i[0]);
    end
  endtask : t_supply

  task t_manual;
    manual_rst_n_i = 1'h0;
    step(3);
    check1(sys_rst_n_o, 1'h0);
    step(17);
    manual_rst_n_i = 1'h1;
    rel_count(n);
    checkn(n, H + 2);
  endtask : t_manual

  task t_watchdog;
    step(3 * K);
    check1(wdog_expired_n_o, 1'h1);
    check1(sys_rst_n_o, 1'h1);
    kick_en = 1'h0;
    n = 0;
    while (wdog_expired_n_o !== 1'h0 && n < 1000) begin
      step(1);
      n++;
    end
    checkn(int'(n <= K + 20), 1);
    step(2);
    check1(sys_rst_n_o, 1'h0);
    rel_count(n);
    checkn(int'(n >= H - 3 && n <= H), 1);
    check1(wdog_expired_n_o, 1'h0);
    supply_ok_i = 1'h0;
    step(2);
    check1(wdog_expired_n_o, 1'h1);
    supply_ok_i = 1'h1;
    rel_count(n);
    kick_en = 1'h1;
    step(3 * K);
    check1(wdog_expired_n_o, 1'h1);
  endtask : t_watchdog

  initial sys_clk_i = 1'h0;
  always #5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  always @(negedge sys_clk_i) begin
    if (rst_i === 1'h0) check1(sys_rst_o, ~sys_rst_n_o);
  end

  initial begin
    {err_count, checks, cyc} = '0;
    rst_i = 1'h1;
    supply_ok_i = 1'h1;
    manual_rst_n_i = 1'h1;
    mem_ce_n_i = 1'h1;
    kick_en = 1'h1;
    step(2);
    t_powerup();
    t_supply();
    t_manual();
    t_watchdog();
    finish_test();
  end
endmodule : test_supervisor_reset_watchdog

`default_nettype wire
